/* File: src/ldsp_top.sv */
// Serial load port of a multiplexed LED driver, with register loader and bank scan.
// Assumes a serial master that moves enable only while the serial clock is low.
//
// Notes on behaviour
// - MSB first, bits taken on rising clock.
// - 8 bits, or 8 plus a multiple of 24 up to 128, loads configuration register.
// - A multiple of 24 bits, up to 144, loads display register.
// - Registers change only after enable rises.
// - No address bits; length picks register.
// - Registers writable in any order.
// - Data out changes on falling clock edge.
// - Static 24.5 stage register, clock to dc.
// - Serial clock independent of scan clock.
// - Five banks refreshed between 700-1900 Hz.
// - Chains of up to six devices supported.
// - Enable high: output low, shifting stopped.
// - Enable low, shift, rise latches selected register.
// - Each enable rise starts a blanking interval.
`timescale 1ns/1ps
`default_nettype none
`include "ldsp_consts.svh"

module ldsp_top (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic sclk_i,
   input wire logic sdata_i,
   input wire logic enable_n_i,
   output logic sdata_o,
   output logic [`LDSP_CFG_W-1:0] config_o,
   output logic [`LDSP_DISP_W-1:0] display_o,
   output logic [`LDSP_BANK_W-1:0] bank_o,
   output logic blank_o
);
   import ldsp_pkg::*;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int SLOT_CYC = `LDSP_CLK_HZ / (`LDSP_REFRESH_HZ * `LDSP_BANK_W);
   localparam int BLANK_CYC = (`LDSP_BLANK_NS + `LDSP_CLK_NS - 1) / `LDSP_CLK_NS;
   localparam int MAX_BITS = `LDSP_DISP_BITS * `LDSP_CHAIN_MAX;

   // Length verdict; a device in a chain sees its own field last
   // chains up to six
   function automatic ldsp_len_t len_kind(input logic [`LDSP_CNT_W-1:0] cnt);
      int n;
      n = int'(cnt);
      if (n == 0 || n > MAX_BITS) begin
         return LEN_NONE;
      end else if (n % `LDSP_DISP_BITS == 0) begin
         return LEN_DISP;
      end else if (n >= `LDSP_CFG_BITS && (n - `LDSP_CFG_BITS) % `LDSP_DISP_BITS == 0) begin
         return LEN_CFG;
      end else begin
         return LEN_NONE;
      end
   endfunction : len_kind

   function automatic logic [`LDSP_CNT_W-1:0] sat_inc(input logic [`LDSP_CNT_W-1:0] c);
      if (&c) begin
         return c;
      end
      return c + 1'b1;
   endfunction : sat_inc

   // ------------------------------------------------------------
   // Link domain (serial clock)
   // ------------------------------------------------------------
   ldsp_link_t link;
   ldsp_link_t next_link;
   logic fresh;
   logic dout;

   // Marks the first clock of a frame; set while enable is inactive
   always_ff @(posedge sclk_i or posedge enable_n_i) begin
      if (enable_n_i) begin
         fresh <= 1'b1;
      end else begin
         fresh <= 1'b0;
      end
   end

   always_comb begin
      next_link = link;
      if (!enable_n_i) begin
         next_link.shreg = {link.shreg[`LDSP_DISP_W-2:0], sdata_i};
         next_link.count = fresh ? `LDSP_CNT_W'(1) : sat_inc(link.count);
      end
   end

   always_ff @(posedge sclk_i) begin
      link <= next_link;
   end

   always_ff @(negedge sclk_i or posedge enable_n_i) begin
      if (enable_n_i) begin
         dout <= 1'b0;
      end else begin
         dout <= link.shreg[`LDSP_DISP_W-1];
      end
   end

   assign sdata_o = dout;

   // ------------------------------------------------------------
   // Crossing into the core clock
   // ------------------------------------------------------------
   logic en_sync;

   ldsp_sync #(
      .RESET_VAL(1'b1)
   ) ldsp_sync_i (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .d_i(enable_n_i),
      .q_o(en_sync)
   );

   // ------------------------------------------------------------
   // Core domain
   // ------------------------------------------------------------
   localparam ldsp_core_t CORE_RST = '{
      en_prev: 1'b1,
      pend: 1'b0,
      pend_word: '0,
      load: LD_IDLE,
      blank_cnt: '0,
      blank: 1'b0,
      cfg: `LDSP_CFG_RST,
      disp: `LDSP_DISP_RST,
      scan_cnt: `LDSP_SCAN_W'(SLOT_CYC - 1),
      bank: `LDSP_BANK_RST,
      bank_out: `LDSP_BANK_RST
   };

   ldsp_core_t st;
   ldsp_core_t next_st;
   logic rise;
   ldsp_len_t kind;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic pop;
   ldsp_word_t fifo_out;

   // Link state is quiet once enable is high, so it is read as a static word here
   assign rise = en_sync && !st.en_prev;
   assign kind = len_kind(link.count);

   // Loader stalls during blanking so the queue really fills
   ldsp_fifo #(
      .WIDTH($bits(ldsp_word_t)),
      .DEPTH(`LDSP_FIFO_DEPTH)
   ) ldsp_fifo_i (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .in_valid_i(st.pend),
      .in_ready_o(fifo_in_ready),
      .in_data_i(st.pend_word),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(pop),
      .out_data_o(fifo_out)
   );

   always_comb begin
      next_st = st;
      pop = 1'b0;
      next_st.en_prev = en_sync;

      // Clear on push first, so a new capture in the same cycle wins
      if (st.pend && fifo_in_ready) begin
         next_st.pend = 1'b0;
      end
      if (rise && kind != LEN_NONE) begin
         next_st.pend = 1'b1;
         next_st.pend_word.is_disp = (kind == LEN_DISP);
         if (kind == LEN_DISP) begin
            next_st.pend_word.data = link.shreg;
         end else begin
            next_st.pend_word.data = {16'h0000, link.shreg[`LDSP_CFG_W-1:0]};
         end
      end

      // blank on every rise, then load
      case (st.load)
         LD_IDLE: begin
            if (rise) begin
               next_st.load = LD_BLANK;
               next_st.blank = 1'b1;
               next_st.blank_cnt = `LDSP_BLANK_W'(BLANK_CYC);
            end
         end
         LD_BLANK: begin
            if (rise) begin
               next_st.blank_cnt = `LDSP_BLANK_W'(BLANK_CYC);
            end else if (st.blank_cnt != '0) begin
               next_st.blank_cnt = st.blank_cnt - 1'b1;
            end else if (fifo_out_valid) begin
               pop = 1'b1;
               next_st.blank_cnt = `LDSP_BLANK_W'(BLANK_CYC);
               if (fifo_out.is_disp) begin
                  next_st.disp = fifo_out.data;
               end else begin
                  next_st.cfg = fifo_out.data[`LDSP_CFG_W-1:0];
               end
            end else begin
               next_st.load = LD_IDLE;
               next_st.blank = 1'b0;
            end
         end
         default: begin
            next_st.load = LD_IDLE;
            next_st.blank = 1'b0;
         end
      endcase

      if (st.scan_cnt == '0) begin
         next_st.scan_cnt = `LDSP_SCAN_W'(SLOT_CYC - 1);
         next_st.bank = {st.bank[`LDSP_BANK_W-2:0], st.bank[`LDSP_BANK_W-1]};
      end else begin
         next_st.scan_cnt = st.scan_cnt - 1'b1;
      end
      next_st.bank_out = next_st.blank ? '0 : next_st.bank;
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         st <= CORE_RST;
      end else begin
         st <= next_st;
      end
   end

   assign config_o = st.cfg;
   assign display_o = st.disp;
   assign bank_o = st.bank_out;
   assign blank_o = st.blank;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_SHIFT_IN: assert property (
      @(posedge sclk_i) disable iff (enable_n_i)
      1'b1 |=> (link.shreg[0] == $past(sdata_i))
         && (link.shreg[`LDSP_DISP_W-1:1] == $past(link.shreg[`LDSP_DISP_W-2:0])))
      else $error("serial bit not shifted in MSB first");

   AST_FIRST_BIT: assert property (
      @(posedge sclk_i) disable iff (enable_n_i)
      fresh |=> (link.count == `LDSP_CNT_W'(1)))
      else $error("bit count not restarted at frame start");

   AST_CFG_LOAD: assert property (
      @(posedge clock_i) disable iff (reset_i)
      (pop && !fifo_out.is_disp) |=> (config_o == $past(fifo_out.data[`LDSP_CFG_W-1:0])))
      else $error("configuration register not loaded");

   AST_DISP_LOAD: assert property (
      @(posedge clock_i) disable iff (reset_i)
      (pop && fifo_out.is_disp) |=> (display_o == $past(fifo_out.data)) && $stable(config_o))
      else $error("display register not loaded");

   AST_HOLD: assert property (
      @(posedge clock_i) disable iff (reset_i)
      !pop |=> $stable(display_o) && $stable(config_o))
      else $error("register changed without a load");

   AST_BAD_LEN: assert property (
      @(posedge clock_i) disable iff (reset_i)
      (rise && kind == LEN_NONE && !st.pend && !fifo_out_valid) |=> !st.pend && !fifo_out_valid)
      else $error("unmatched length queued a load");

   AST_BLANK_ON_RISE: assert property (
      @(posedge clock_i) disable iff (reset_i)
      rise |=> blank_o [*8] ##1 (bank_o == '0))
      else $error("enable rise did not blank the display");

   AST_BANK_STEP: assert property (
      @(posedge clock_i) disable iff (reset_i)
      $changed(st.bank) |-> $past(st.scan_cnt) == '0 && $onehot(st.bank))
      else $error("bank stepped off slot boundary");

endmodule : ldsp_top
`default_nettype wire

/* File: src/ldsp_consts.svh */
// Constants of the serial load port: stream lengths, reset values, timing.
// Assumes inclusion by bare name from the package and the design files.
`ifndef LDSP_CONSTS_SVH
`define LDSP_CONSTS_SVH

// Widths
`define LDSP_CFG_W 8
`define LDSP_DISP_W 24
`define LDSP_CNT_W 8
`define LDSP_BANK_W 5
`define LDSP_SCAN_W 12
`define LDSP_BLANK_W 8

// Stream lengths and chain size
`define LDSP_CFG_BITS 8
`define LDSP_DISP_BITS 24
`define LDSP_CHAIN_MAX 6

// Reset values
`define LDSP_CFG_RST 8'h00
`define LDSP_DISP_RST 24'h000000
`define LDSP_BANK_RST 5'h01

// Timing: core clock, scan refresh, blanking interval
`define LDSP_CLK_HZ 20000000
`define LDSP_CLK_NS 50
`define LDSP_REFRESH_HZ 1000
`define LDSP_BLANK_NS 2000

// Load queue depth
`define LDSP_FIFO_DEPTH 4

`endif

/* File: src/ldsp_pkg.sv */
// Types shared by the serial load port design files.
// Assumes ldsp_consts.svh is on the include path.
`default_nettype none
`include "ldsp_consts.svh"

package ldsp_pkg;

   // Link side shift state
   typedef struct packed {
      logic [`LDSP_DISP_W-1:0] shreg;
      logic [`LDSP_CNT_W-1:0] count;
   } ldsp_link_t;

   // One completed transfer, queued for loading
   typedef struct packed {
      logic is_disp;
      logic [`LDSP_DISP_W-1:0] data;
   } ldsp_word_t;

   // Stream length verdict
   typedef enum logic [2:0] {
      LEN_NONE = 3'b001,
      LEN_CFG = 3'b010,
      LEN_DISP = 3'b100
   } ldsp_len_t;

   // Register loader
   typedef enum logic [1:0] {
      LD_IDLE = 2'b01,
      LD_BLANK = 2'b10
   } ldsp_load_t;

   typedef struct packed {
      logic en_prev;
      logic pend;
      ldsp_word_t pend_word;
      ldsp_load_t load;
      logic [`LDSP_BLANK_W-1:0] blank_cnt;
      logic blank;
      logic [`LDSP_CFG_W-1:0] cfg;
      logic [`LDSP_DISP_W-1:0] disp;
      logic [`LDSP_SCAN_W-1:0] scan_cnt;
      logic [`LDSP_BANK_W-1:0] bank;
      logic [`LDSP_BANK_W-1:0] bank_out;
   } ldsp_core_t;

endpackage : ldsp_pkg
`default_nettype wire

/* File: src/ldsp_sync.sv */
// Two-stage level synchroniser into the core clock.
// Assumes a level input from another clock domain or a pin.
`timescale 1ns/1ps
`default_nettype none

module ldsp_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic d_i,
   output logic q_o
);
   import ldsp_pkg::*;

   typedef struct packed {
      logic meta;
      logic stable;
   } ldsp_sync_t;

   ldsp_sync_t st;
   ldsp_sync_t next_st;

   // First stage feeds only the second
   always_comb begin
      next_st.meta = d_i;
      next_st.stable = st.meta;
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         st <= '{meta: RESET_VAL, stable: RESET_VAL};
      end else begin
         st <= next_st;
      end
   end

   assign q_o = st.stable;

endmodule : ldsp_sync
`default_nettype wire

/* File: src/ldsp_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on one clock.
`timescale 1ns/1ps
`default_nettype none

module ldsp_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 4
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   import ldsp_pkg::*;

   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW:0] wr;
      logic [PW:0] rd;
   } ldsp_fifo_t;

   ldsp_fifo_t st;
   ldsp_fifo_t next_st;
   logic full;
   logic empty;

   // Extra pointer bit tells full from empty
   assign empty = (st.wr == st.rd);
   assign full = (st.wr[PW] != st.rd[PW]) && (st.wr[PW-1:0] == st.rd[PW-1:0]);
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = st.mem[st.rd[PW-1:0]];

   always_comb begin
      next_st = st;
      if (in_valid_i && !full) begin
         next_st.mem[st.wr[PW-1:0]] = in_data_i;
         next_st.wr = st.wr + 1'b1;
      end
      if (out_ready_i && !empty) begin
         next_st.rd = st.rd + 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule : ldsp_fifo
`default_nettype wire

/* File: tb/ldsp_master.sv */
// Serial master model for the load port link.
// Assumes the bench calls frame() only while enable is idle.
`timescale 1ns/1ps
`default_nettype none

module ldsp_master (
   output logic sclk_o,
   output logic sdata_o,
   output logic enable_n_o,
   input wire logic loop_i
);
   logic [143:0] cap;

   initial begin
      sclk_o = 1'b0;
      sdata_o = 1'b0;
      enable_n_o = 1'b1;
      cap = '0;
   end

   // ------------------------------------------------------------
   // Frame
   // ------------------------------------------------------------
   // 160 ns clock, enable moved with clock low
   task automatic frame(input int n, input logic [143:0] bits);
      // phase kept off the core clock
      #13;
      enable_n_o = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         // MSB first, length set by caller
         sdata_o = bits[i];
         #80;
         sclk_o = 1'b1;
         cap = {cap[142:0], loop_i};
         #80;
         sclk_o = 1'b0;
      end
      #80;
      enable_n_o = 1'b1;
      // Released line shows the inverse so a stale bit cannot pass
      sdata_o = ~sdata_o;
   endtask : frame
endmodule : ldsp_master
`default_nettype wire

/* File: tb/ldsp_top_bench.sv */
// Self-checking bench of the serial load port.
// Assumes the design files and ldsp_consts.svh are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ldsp_consts.svh"

module ldsp_top_bench;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic sclk, sdata_in, enable_n, sdata_out, blank;
   logic [`LDSP_CFG_W-1:0] config_val;
   logic [`LDSP_DISP_W-1:0] display_val;
   logic [`LDSP_BANK_W-1:0] bank;
   int miscompares = 0;
   int checked = 0;
   // Core cycles that each bank stays lit at the nominal refresh rate
   localparam int SLOT_CYC = `LDSP_CLK_HZ / (`LDSP_REFRESH_HZ * `LDSP_BANK_W);

   always #25 clock = ~clock;

   ldsp_top ldsp_top_i (
      .clock_i(clock),
      .reset_i(reset),
      .sclk_i(sclk),
      .sdata_i(sdata_in),
      .enable_n_i(enable_n),
      .sdata_o(sdata_out),
      .config_o(config_val),
      .display_o(display_val),
      .bank_o(bank),
      .blank_o(blank)
   );

   ldsp_master ldsp_master_i (
      .sclk_o(sclk),
      .sdata_o(sdata_in),
      .enable_n_o(enable_n),
      .loop_i(sdata_out)
   );

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Sends a frame and waits out the blanking that loads it
   task automatic run(input int n, input logic [143:0] bits);
      logic [7:0] c0;
      logic [23:0] d0;
      int k;
      c0 = config_val;
      d0 = display_val;
      ldsp_master_i.frame(n, bits);
      @(posedge clock);
      #1;
      check("cfg while idle", {16'h0, c0}, {16'h0, config_val});
      check("disp while idle", d0, display_val);
      check("data out idle", 24'h0, {23'h0, sdata_out});
      k = 0;
      while (blank !== 1'b1 && k < 20) begin
         @(posedge clock);
         #1;
         k++;
      end
      check("blank start", 24'h1, {23'h0, blank});
      check("bank blanked", 24'h0, {19'h0, bank});
      k = 0;
      while (blank !== 1'b0 && k < 300) begin
         @(posedge clock);
         #1;
         k++;
      end
      check("blank end", 24'h0, {23'h0, blank});
   endtask : run

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_single();
      run(8, 144'ha5);
      check("cfg 8", 24'ha5, {16'h0, config_val});
      check("disp kept", 24'h0, display_val);
      run(24, 144'h3c5a96);
      check("disp 24", 24'h3c5a96, display_val);
      check("cfg kept", 24'ha5, {16'h0, config_val});
      run(8, 144'h42);
      check("cfg again", 24'h42, {16'h0, config_val});
      $display("test single done");
   endtask : t_single

   task automatic t_bad();
      int lens[3] = '{12, 25, 47};
      foreach (lens[i]) begin
         run(lens[i], {144{1'b1}});
         check("cfg unmatched", 24'h42, {16'h0, config_val});
         check("disp unmatched", 24'h3c5a96, display_val);
      end
      $display("test bad done");
   endtask : t_bad

   task automatic t_chain();
      run(48, {96'h0, 24'h123456, 24'h654321});
      check("disp 48", 24'h654321, display_val);
      check("loopback", 24'h123456, ldsp_master_i.cap[23:0]);
      run(32, {112'h0, 24'hffffff, 8'h5b});
      check("cfg 32", 24'h5b, {16'h0, config_val});
      run(144, {120'h0, 24'h9e37b1});
      check("disp 144", 24'h9e37b1, display_val);
      run(128, {120'h0, 8'h81});
      check("cfg 128", 24'h81, {16'h0, config_val});
      $display("test chain done");
   endtask : t_chain

   task automatic t_scan();
      logic [4:0] b0;
      int k;
      for (int r = 0; r < 2; r++) begin
         b0 = bank;
         k = 0;
         while (bank === b0 && k < 4100) begin
            @(posedge clock);
            #1;
            k++;
         end
      end
      check("bank one hot", 24'h1, {23'h0, $onehot(bank)});
      check("bank period", 24'(SLOT_CYC), k[23:0]);
      $display("test scan done");
   endtask : t_scan

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      repeat (4) @(posedge clock);
      #1;
      check("cfg reset", 24'h0, {16'h0, config_val});
      check("bank reset", 24'h1, {19'h0, bank});
      t_single();
      t_bad();
      t_chain();
      t_scan();
      close_out();
   end

   initial begin
      #2000000;
      miscompares++;
      close_out();
   end
endmodule : ldsp_top_bench
`default_nettype wire
